// File: pkg/usart_chan_pkg.sv
// Register map, status layout and command bits of the serial channel status block
package usart_chan_pkg;
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_MODE = 8'h04;
	localparam logic [7:0] OFS_INT_ENABLE = 8'h08;
	localparam logic [7:0] OFS_INT_DISABLE = 8'h0c;
	localparam logic [7:0] OFS_INT_MASK = 8'h10;
	localparam logic [7:0] OFS_CHAN_STATUS = 8'h14;
	localparam logic [7:0] OFS_RX_HOLD = 8'h18;
	localparam logic [7:0] OFS_TX_HOLD = 8'h1c;
	localparam logic [7:0] OFS_BAUD_DIV = 8'h20;
	localparam logic [7:0] OFS_TIMEOUT_VAL = 8'h24;
	localparam int FLAG_W = 10;
	localparam int BIT_RX_READY = 0;
	localparam int BIT_TX_FREE = 1;
	localparam int BIT_RX_BREAK = 2;
	localparam int BIT_RX_DONE = 3;
	localparam int BIT_TX_DONE = 4;
	localparam int BIT_OVERRUN = 5;
	localparam int BIT_FRAMING = 6;
	localparam int BIT_PARITY = 7;
	localparam int BIT_TIMEOUT = 8;
	localparam int BIT_TX_EMPTY = 9;
	localparam logic [9:0] STATUS_RESET = 10'h018;
	localparam logic [9:0] MASK_RESET = 10'h000;
	localparam int CTL_RX_ON = 4;
	localparam int CTL_RX_OFF = 5;
	localparam int CTL_TX_ON = 6;
	localparam int CTL_TX_OFF = 7;
	localparam int CTL_CLEAR_STATUS = 8;
	localparam int CTL_BEGIN_BREAK = 9;
	localparam int CTL_END_BREAK = 10;
	localparam int CTL_ARM_TIMEOUT = 11;
	localparam int MODE_CLKSEL_LO = 4;
	localparam int MODE_SYNC = 8;
	localparam int CHAR_W = 9;
	localparam int DIV_W = 16;
	localparam int OVERSAMPLE = 16;
	localparam int PRESCALE_MCK8 = 8;
	localparam int TIMEOUT_BITS_PER_UNIT = 4;
	// Receive-side events from the shift logic
	typedef struct packed {
		logic charDone;
		logic [8:0] charData;
		logic stopLow;
		logic parityBad;
		logic breakEdge;
	} rx_event_type;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_SHIFT = 2'b01,
		TX_BREAK = 2'b11
	} tx_state_type;
endpackage : usart_chan_pkg

// File: logic/baud_divider.sv
// Baud rate divider producing one-cycle tick enables
`timescale 1ns/1ps
`default_nettype none
module baud_divider #(
	parameter int DIV_W = 16
) (
	input wire logic ref_clk, // System clock
	input wire logic srst, // Synchronous reset
	input wire logic srcTick, // Selected source clock enable
	input wire logic [DIV_W-1:0] divisor, // Clock divisor
	input wire logic syncMode, // Synchronous mode
	input wire logic extSync, // Synchronous with external clock
	output logic bitTick // One pulse per bit period
);
	logic [DIV_W-1:0] divCnt_q;
	logic [3:0] overCnt_q;
	logic divTick;
	if (DIV_W < 2) begin : g_bad_div_width
		$error("DIV_W too small");
	end
	// Divisor zero stops the clock, one bypasses; a count above a lowered divisor ends at once
	assign divTick = srcTick && divisor != DIV_W'(0) && divCnt_q >= divisor - DIV_W'(1);
	assign bitTick = extSync ? srcTick : (syncMode ? divTick : (divTick && overCnt_q == 4'hf)); // R17 R18
	always_ff @(posedge ref_clk) begin
		if (srst || divisor == DIV_W'(0)) begin
			divCnt_q <= '0;
			overCnt_q <= '0;
		end else if (srcTick) begin
			divCnt_q <= divTick ? '0 : divCnt_q + 1'b1;
			if (divTick) overCnt_q <= overCnt_q + 4'h1;
		end
	end
	a_stopped_clock: assert property (@(posedge ref_clk) disable iff (srst) // R17
		(divisor == DIV_W'(0) && !extSync) |-> !bitTick) else $error("tick with zero divisor");
endmodule : baud_divider
`default_nettype wire

// File: logic/usart_status_data_baud.sv
// Status, mask, holding and baud registers of one serial channel
// What this block does
// R1 - Writing one to a disable bit clears that mask bit; zero does nothing.
// R2 - Mask register resets to zero, reads one per enabled source.
// R3 - Disable, mask and status share one ten-bit layout.
// R4 - Status resets with both transfer-done bits set.
// R5 - Char ready sets on receive, clears on read or receiver off.
// R6 - Holding free only when holding empty and no break pending.
// R7 - Holding free and all empty zero while transmitter off; enable sets.
// R8 - Break seen sets on break or break end, sticky until status clear.
// R9 - Transfer-done flags follow the data controller end signals.
// R10 - Overrun sets when a char lands while char ready set.
// R11 - Framing error sets on low stop bit, sticky.
// R12 - Parity error sets on bad parity or multidrop high, sticky.
// R13 - Timeout sets on expiry after arming; zero value keeps it clear.
// R14 - All empty only when holding and shifter empty and no break.
// R15 - Receive holding reads nine-bit right-aligned char, rest zero.
// R16 - Transmit holding write queues a char after the current one.
// R17 - Divisor zero stops, one bypasses, else divides by 16*n or n.
// R18 - Divisor has no effect in synchronous mode with external clock.
// R19 - Software uses an even divisor in synchronous mode.
// R20 - Software never uses bypass with the undivided master clock.
// R21 - Status clear command clears parity, framing, overrun, break seen.
// R22 - Writing one to an enable bit sets that mask bit.
// R23 - Arming waits for a new character before counting starts.
// R24 - Interrupt asserts while any flag is set with its mask set.
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module usart_status_data_baud #(
	parameter int TO_W = 8
) (
	input wire logic ref_clk, // 20 MHz system clock
	input wire logic srst, // Synchronous reset, active high
	input wire logic [7:0] regAddr, // Register byte address
	input wire logic [31:0] regWdata, // Write data
	input wire logic regWrite, // Write strobe
	input wire logic regRead, // Read strobe
	output logic [31:0] regRdata, // Read data, cycle after strobe
	input wire logic serialClkPin, // External serial clock pin
	input wire logic rxDonePin, // Receive data controller end of transfer
	input wire logic txDonePin, // Transmit data controller end of transfer
	input wire usart_chan_pkg::rx_event_type rxEvent, // Receive shift events
	output logic [8:0] txChar, // Character to shifter
	output logic txLoad, // Shifter load pulse
	input wire logic txShiftBusy, // Shifter still sending
	output logic txBreakOn, // Break being sent
	output logic bitTickOut, // Bit period enable
	output logic irq // Channel interrupt
);
	logic [usart_chan_pkg::FLAG_W-1:0] mask_q, status;
	logic [8:0] rxHold_q, txHold_q;
	logic rxReady_q, overrun_q, framing_q, parity_q, breakSeen_q, timeout_q;
	logic txEnabled_q, rxEnabled_q, holdFull_q, breakReq_q;
	logic [15:0] divisor_q;
	logic [9:0] mode_q;
	logic [TO_W-1:0] toValue_q, toCnt_q;
	logic toArmed_q, toRun_q;
	logic [1:0] quarterCnt_q;
	logic [2:0] pre8_q;
	logic [2:0] sckSync_q;
	logic [1:0] rxDoneSync_q, txDoneSync_q;
	usart_chan_pkg::tx_state_type txState_q;
	logic wrCtl, wrEn, wrDis, wrTx, wrDiv, wrTo, wrMode, rdRx, clearCmd, armCmd;
	logic srcTick, bitTick, extSync, sckRise, txOnCmd, rxOffCmd, moveToShift;
	logic [31:0] rdMux;
	if (TO_W < 1 || TO_W > 16) begin : g_bad_to_width
		$error("TO_W out of range");
	end
	assign wrCtl = regWrite && regAddr == usart_chan_pkg::OFS_CONTROL;
	assign wrMode = regWrite && regAddr == usart_chan_pkg::OFS_MODE;
	assign wrEn = regWrite && regAddr == usart_chan_pkg::OFS_INT_ENABLE;
	assign wrDis = regWrite && regAddr == usart_chan_pkg::OFS_INT_DISABLE;
	assign wrTx = regWrite && regAddr == usart_chan_pkg::OFS_TX_HOLD;
	assign wrDiv = regWrite && regAddr == usart_chan_pkg::OFS_BAUD_DIV;
	assign wrTo = regWrite && regAddr == usart_chan_pkg::OFS_TIMEOUT_VAL;
	assign rdRx = regRead && regAddr == usart_chan_pkg::OFS_RX_HOLD;
	assign clearCmd = wrCtl && regWdata[usart_chan_pkg::CTL_CLEAR_STATUS];
	assign armCmd = (wrCtl && regWdata[usart_chan_pkg::CTL_ARM_TIMEOUT]) || wrTo;
	assign txOnCmd = wrCtl && regWdata[usart_chan_pkg::CTL_TX_ON] && !regWdata[usart_chan_pkg::CTL_TX_OFF];
	assign rxOffCmd = wrCtl && regWdata[usart_chan_pkg::CTL_RX_OFF];
	// Clock source: master, master/8, or synchronised external edge
	assign sckRise = sckSync_q[1] && !sckSync_q[2];
	assign srcTick = mode_q[usart_chan_pkg::MODE_CLKSEL_LO + 1] ? sckRise
		: (mode_q[usart_chan_pkg::MODE_CLKSEL_LO] ? pre8_q == 3'h7 : 1'b1);
	assign extSync = mode_q[usart_chan_pkg::MODE_SYNC] && mode_q[usart_chan_pkg::MODE_CLKSEL_LO + 1]; // R18
	baud_divider #(
		.DIV_W(usart_chan_pkg::DIV_W)
	) u_div (
		.ref_clk(ref_clk),
		.srst(srst),
		.srcTick(srcTick),
		.divisor(divisor_q),
		.syncMode(mode_q[usart_chan_pkg::MODE_SYNC]),
		.extSync(extSync),
		.bitTick(bitTick)
	);
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sckSync_q <= '0;
			// Done flags read active from reset on
			rxDoneSync_q <= {2{usart_chan_pkg::STATUS_RESET[usart_chan_pkg::BIT_RX_DONE]}}; // R4
			txDoneSync_q <= {2{usart_chan_pkg::STATUS_RESET[usart_chan_pkg::BIT_TX_DONE]}}; // R4
			pre8_q <= '0;
			mode_q <= '0;
			divisor_q <= '0;
		end else begin
			sckSync_q <= {sckSync_q[1:0], serialClkPin};
			rxDoneSync_q <= {rxDoneSync_q[0], rxDonePin};
			txDoneSync_q <= {txDoneSync_q[0], txDonePin};
			pre8_q <= pre8_q + 3'h1;
			if (wrMode) mode_q <= regWdata[9:0];
			if (wrDiv) divisor_q <= regWdata[15:0]; // R17
		end
	end
	// Mask: enable sets, disable clears; enable wins if both in one write is impossible
	always_ff @(posedge ref_clk) begin
		if (srst) mask_q <= usart_chan_pkg::MASK_RESET; // R2
		else if (wrEn) mask_q <= mask_q | regWdata[9:0]; // R22
		else if (wrDis) mask_q <= mask_q & ~regWdata[9:0]; // R1
	end
	// Receive flags; set wins over clear
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rxReady_q <= 1'b0;
			rxEnabled_q <= 1'b0;
			rxHold_q <= '0;
			overrun_q <= 1'b0;
			framing_q <= 1'b0;
			parity_q <= 1'b0;
			breakSeen_q <= 1'b0;
		end else begin
			if (wrCtl && regWdata[usart_chan_pkg::CTL_RX_ON] && !regWdata[usart_chan_pkg::CTL_RX_OFF])
				rxEnabled_q <= 1'b1;
			else if (rxOffCmd) rxEnabled_q <= 1'b0;
			if (rxEvent.charDone && rxEnabled_q) begin
				rxHold_q <= rxEvent.charData; // R15
				rxReady_q <= 1'b1; // R5
			end else if (rdRx || rxOffCmd) rxReady_q <= 1'b0; // R5
			if (rxEvent.charDone && rxEnabled_q && rxReady_q) overrun_q <= 1'b1; // R10
			else if (clearCmd) overrun_q <= 1'b0; // R21
			if (rxEvent.stopLow) framing_q <= 1'b1; // R11
			else if (clearCmd) framing_q <= 1'b0; // R21
			if (rxEvent.parityBad) parity_q <= 1'b1; // R12
			else if (clearCmd) parity_q <= 1'b0; // R21
			if (rxEvent.breakEdge) breakSeen_q <= 1'b1; // R8
			else if (clearCmd) breakSeen_q <= 1'b0; // R21
		end
	end
	// Timeout: arm waits for a character, then counts 4-bit units
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			toValue_q <= '0;
			toCnt_q <= '0;
			toArmed_q <= 1'b0;
			toRun_q <= 1'b0;
			timeout_q <= 1'b0;
			quarterCnt_q <= '0;
		end else begin
			if (wrTo) toValue_q <= regWdata[TO_W-1:0];
			if (armCmd) begin
				toArmed_q <= 1'b1; // R23
				toRun_q <= 1'b0;
				timeout_q <= 1'b0;
			end else if (rxEvent.charDone && (toArmed_q || toRun_q)) begin
				toArmed_q <= 1'b0;
				toRun_q <= toValue_q != '0; // R13
				toCnt_q <= toValue_q;
				quarterCnt_q <= '0;
			end else if (toRun_q && bitTick) begin
				quarterCnt_q <= quarterCnt_q + 2'h1;
				if (quarterCnt_q == 2'h3) begin
					if (toCnt_q == TO_W'(1)) begin
						toRun_q <= 1'b0;
						timeout_q <= 1'b1; // R13
					end
					toCnt_q <= toCnt_q - TO_W'(1);
				end
			end
			if (wrTo && regWdata[TO_W-1:0] == '0) timeout_q <= 1'b0; // R13
		end
	end
	// Transmit holding and break control
	assign moveToShift = txEnabled_q && holdFull_q && !txShiftBusy && txState_q != usart_chan_pkg::TX_BREAK;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			txEnabled_q <= 1'b0;
			holdFull_q <= 1'b0;
			txHold_q <= '0;
			breakReq_q <= 1'b0;
			txState_q <= usart_chan_pkg::TX_IDLE;
			txChar <= '0;
			txLoad <= 1'b0;
		end else begin
			txLoad <= moveToShift;
			if (txOnCmd) txEnabled_q <= 1'b1; // R7
			else if (wrCtl && regWdata[usart_chan_pkg::CTL_TX_OFF]) txEnabled_q <= 1'b0; // R7
			if (wrTx) begin
				txHold_q <= regWdata[8:0]; // R16
				holdFull_q <= 1'b1;
			end else if (moveToShift) holdFull_q <= 1'b0;
			if (moveToShift) txChar <= txHold_q;
			if (wrCtl && regWdata[usart_chan_pkg::CTL_BEGIN_BREAK] && txState_q != usart_chan_pkg::TX_BREAK)
				breakReq_q <= 1'b1; // R6
			case (txState_q)
				usart_chan_pkg::TX_IDLE: begin
					if (moveToShift) txState_q <= usart_chan_pkg::TX_SHIFT;
					else if (breakReq_q && !holdFull_q && !txShiftBusy) begin
						txState_q <= usart_chan_pkg::TX_BREAK;
						breakReq_q <= 1'b0;
					end
				end
				usart_chan_pkg::TX_SHIFT: begin
					if (!txShiftBusy && !txLoad) txState_q <= usart_chan_pkg::TX_IDLE;
				end
				usart_chan_pkg::TX_BREAK: begin
					if (wrCtl && regWdata[usart_chan_pkg::CTL_END_BREAK]) txState_q <= usart_chan_pkg::TX_IDLE;
				end
				default: txState_q <= usart_chan_pkg::TX_IDLE;
			endcase
		end
	end
	always_comb begin
		status = '0;
		status[usart_chan_pkg::BIT_RX_READY] = rxReady_q;
		status[usart_chan_pkg::BIT_TX_FREE] = txEnabled_q && !holdFull_q && !breakReq_q; // R6 R7
		status[usart_chan_pkg::BIT_RX_BREAK] = breakSeen_q;
		status[usart_chan_pkg::BIT_RX_DONE] = rxDoneSync_q[1]; // R9
		status[usart_chan_pkg::BIT_TX_DONE] = txDoneSync_q[1]; // R9
		status[usart_chan_pkg::BIT_OVERRUN] = overrun_q;
		status[usart_chan_pkg::BIT_FRAMING] = framing_q;
		status[usart_chan_pkg::BIT_PARITY] = parity_q;
		status[usart_chan_pkg::BIT_TIMEOUT] = timeout_q;
		status[usart_chan_pkg::BIT_TX_EMPTY] = txEnabled_q && !holdFull_q && !txShiftBusy && !txLoad
			&& txState_q == usart_chan_pkg::TX_IDLE && !breakReq_q; // R14 R7
	end
	// Unmapped and write-only addresses read zero
	assign rdMux = (regAddr == usart_chan_pkg::OFS_INT_MASK) ? {22'h0, mask_q} // R3
		: (regAddr == usart_chan_pkg::OFS_CHAN_STATUS) ? {22'h0, status} // R3
		: (regAddr == usart_chan_pkg::OFS_RX_HOLD) ? {23'h0, rxHold_q} // R15
		: (regAddr == usart_chan_pkg::OFS_BAUD_DIV) ? {16'h0, divisor_q}
		: (regAddr == usart_chan_pkg::OFS_MODE) ? {22'h0, mode_q}
		: (regAddr == usart_chan_pkg::OFS_TIMEOUT_VAL) ? {{(32-TO_W){1'b0}}, toValue_q}
		: 32'h0;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			regRdata <= '0;
			irq <= 1'b0;
			txBreakOn <= 1'b0;
			bitTickOut <= 1'b0;
		end else begin
			regRdata <= regRead ? rdMux : 32'h0;
			irq <= |(status & mask_q); // R24
			txBreakOn <= txState_q == usart_chan_pkg::TX_BREAK;
			bitTickOut <= bitTick;
		end
	end
	a_disable_clears: assert property (@(posedge ref_clk) disable iff (srst) (wrDis && !wrEn) |=> ((mask_q & $past(regWdata[9:0])) == 10'h0)) else $error("disable left mask bit"); // R1
	a_enable_sets: assert property (@(posedge ref_clk) disable iff (srst) wrEn |=> ((mask_q & $past(regWdata[9:0])) == $past(regWdata[9:0]))) else $error("enable missed mask bit"); // R22
	a_status_reset: assert property (@(posedge ref_clk) disable iff (srst) $past(srst) |-> // R4 R2
		(status == usart_chan_pkg::STATUS_RESET && mask_q == usart_chan_pkg::MASK_RESET)) else $error("bad reset status");
	a_rx_ready_set: assert property (@(posedge ref_clk) disable iff (srst) (rxEvent.charDone && rxEnabled_q) |=> rxReady_q) else $error("char ready not set"); // R5
	a_overrun_set: assert property (@(posedge ref_clk) disable iff (srst) (rxEvent.charDone && rxEnabled_q && rxReady_q) |=> overrun_q) else $error("overrun missed"); // R10
	a_sticky_clear: assert property (@(posedge ref_clk) disable iff (srst) (clearCmd && !rxEvent.stopLow && !rxEvent.parityBad) |=> (!framing_q && !parity_q)) else $error("clear ignored"); // R21
	a_tx_off_zero: assert property (@(posedge ref_clk) disable iff (srst) !txEnabled_q |-> (!status[1] && !status[9])) else $error("flags set while off"); // R7
	a_tx_on_sets: assert property (@(posedge ref_clk) disable iff (srst) (txOnCmd && !txEnabled_q) |=> (status[1] && status[9])) else $error("enable did not set flags"); // R7
	a_irq_follows: assert property (@(posedge ref_clk) disable iff (srst) |(status & mask_q) |=> irq) else $error("irq missing"); // R24
	a_done_follows: assert property (@(posedge ref_clk) disable iff (srst) rxDonePin ##1 rxDonePin ##1 rxDonePin |-> status[3]) else $error("rx done lost"); // R9
	c_overrun: cover property (@(posedge ref_clk) disable iff (srst) $rose(overrun_q));
	c_timeout: cover property (@(posedge ref_clk) disable iff (srst) $rose(timeout_q));
	c_break: cover property (@(posedge ref_clk) disable iff (srst) $rose(txBreakOn));
	c_irq: cover property (@(posedge ref_clk) disable iff (srst) $rose(irq));
endmodule : usart_status_data_baud
`default_nettype wire

// File: dv/serial_far_end.sv
// Remote shifter model: takes loaded characters and plays received ones
`timescale 1ns/1ps
`default_nettype none
module serial_far_end #(
	parameter int BUSY_CYC = 40
) (
	input wire logic ref_clk, // System clock
	input wire logic [8:0] txChar, // Character from holding register
	input wire logic txLoad, // Load pulse
	output logic txShiftBusy, // Shifter still sending
	output var usart_chan_pkg::rx_event_type rxEvent, // Receive events
	output var logic [8:0] lastTx, // Last character taken
	output var logic [7:0] loadCount // Characters taken
);
	int busyCnt = 0;
	// Busy already in the load cycle, so a second load cannot slip in behind it
	assign txShiftBusy = txLoad || busyCnt != 0;
	initial begin
		rxEvent = '0;
		lastTx = '0;
		loadCount = '0;
	end
	always @(posedge ref_clk) begin
		if (txLoad) begin
			lastTx <= txChar;
			loadCount <= loadCount + 8'h01;
			busyCnt <= BUSY_CYC;
		end else if (busyCnt != 0) begin
			busyCnt <= busyCnt - 1;
		end
	end
	task automatic sendChar(input logic done, input logic [8:0] data, input logic stopLow, input logic parBad,
		input logic brk);
		@(posedge ref_clk);
		rxEvent <= {done, data, stopLow, parBad, brk};
		@(posedge ref_clk);
		// Stale data bits inverted so a late sample shows up
		rxEvent <= {1'b0, ~data, 3'b000};
	endtask : sendChar
endmodule : serial_far_end
`default_nettype wire

// File: dv/testbench.sv
// Register-level testbench of the serial channel status block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic ref_clk = 0, srst = 1, regWrite = 0, regRead = 0, serialClkPin = 0, rxDonePin = 1, txDonePin = 1;
	logic [7:0] regAddr = '0;
	logic [31:0] regWdata = '0, regRdata;
	logic [8:0] txChar, lastTx;
	logic [7:0] loadCount;
	logic txLoad, txShiftBusy, txBreakOn, bitTickOut, irq;
	usart_chan_pkg::rx_event_type rxEvent;
	int n_fail = 0, checked = 0, cycles = 0, extCnt = 0, g, n, i;
	logic [31:0] modes [6] = '{32'h000, 32'h100, 32'h010, 32'h120, 32'h120, 32'h010};
	logic [31:0] divs [6] = '{32'h2, 32'h4, 32'h2, 32'h2, 32'h6, 32'h1};
	int gaps [6] = '{32, 4, 256, 10, 10, 128};

	usart_status_data_baud dut_u (.ref_clk(ref_clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
		.regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .serialClkPin(serialClkPin),
		.rxDonePin(rxDonePin), .txDonePin(txDonePin), .rxEvent(rxEvent), .txChar(txChar), .txLoad(txLoad),
		.txShiftBusy(txShiftBusy), .txBreakOn(txBreakOn), .bitTickOut(bitTickOut), .irq(irq));
	serial_far_end far_u (.ref_clk(ref_clk), .txChar(txChar), .txLoad(txLoad), .txShiftBusy(txShiftBusy),
		.rxEvent(rxEvent), .lastTx(lastTx), .loadCount(loadCount));

	initial begin
		forever #25 ref_clk = ~ref_clk;
	end
	// External serial clock, rising every 10 cycles
	always @(posedge ref_clk) begin
		extCnt <= (extCnt == 4) ? 0 : extCnt + 1;
		if (extCnt == 4) serialClkPin <= ~serialClkPin;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			conclude();
		end
	end

	task automatic step(input int k);
		repeat (k) begin
			@(posedge ref_clk);
			#1;
		end
	endtask : step
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWdata <= v;
		@(posedge ref_clk);
		regWrite <= 1'b0;
	endtask : wr
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		@(posedge ref_clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRead <= 1'b0;
		#1;
		chk(regRdata & m, exp);
	endtask : rc
	task automatic tickGap(output int gap);
		for (int j = 0; j < 3000 && bitTickOut !== 1'b1; j++) step(1);
		step(1);
		gap = 1;
		for (int j = 0; j < 3000 && bitTickOut !== 1'b1; j++) begin
			step(1);
			gap++;
		end
	endtask : tickGap
	task automatic conclude();
		$display("Comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude

	initial begin
		step(20);
		srst <= 1'b0;
		rc(8'h10, '1, 32'h0);
		rc(8'h14, '1, 32'h18);
		rc(8'h18, '1, 32'h0);
		rc(8'h20, '1, 32'h0);
		rc(8'h2c, '1, 32'h0);
		wr(8'h08, 32'h3ff);
		rc(8'h10, '1, 32'h3ff);
		step(2);
		chk(irq, 1);
		wr(8'h10, 32'h0);
		rc(8'h10, '1, 32'h3ff);
		wr(8'h0c, 32'h005);
		rc(8'h10, '1, 32'h3fa);
		wr(8'h0c, 32'h0);
		rc(8'h10, '1, 32'h3fa);
		wr(8'h0c, 32'h3ff);
		rc(8'h10, '1, 32'h0);
		step(2);
		chk(irq, 0);
		wr(8'h08, 32'h008);
		step(2);
		chk(irq, 1);
		@(posedge ref_clk) rxDonePin <= 1'b0;
		step(4);
		rc(8'h14, 32'h18, 32'h10);
		chk(irq, 0);
		@(posedge ref_clk) rxDonePin <= 1'b1;
		wr(8'h0c, 32'h3ff);
		rc(8'h14, 32'h202, 32'h0);
		wr(8'h00, 32'h40);
		step(2);
		rc(8'h14, 32'h202, 32'h202);
		wr(8'h1c, 32'h155);
		wr(8'h1c, 32'h0aa);
		step(3);
		rc(8'h14, 32'h202, 32'h0);
		chk(lastTx, 32'h155);
		step(100);
		rc(8'h14, 32'h202, 32'h202);
		chk(lastTx, 32'h0aa);
		chk(loadCount, 32'h2);
		wr(8'h00, 32'h200);
		step(2);
		// Break now in the shifter: holding free again, all empty stays low
		rc(8'h14, 32'h202, 32'h002);
		chk(txBreakOn, 1);
		wr(8'h00, 32'h400);
		step(3);
		chk(txBreakOn, 0);
		rc(8'h14, 32'h202, 32'h202);
		wr(8'h00, 32'h80);
		step(2);
		rc(8'h14, 32'h202, 32'h0);
		wr(8'h00, 32'h10);
		far_u.sendChar(1, 9'h1a5, 0, 0, 0);
		step(3);
		rc(8'h14, 32'h1, 32'h1);
		rc(8'h18, '1, 32'h1a5);
		rc(8'h14, 32'h1, 32'h0);
		far_u.sendChar(1, 9'h0f3, 0, 0, 0);
		far_u.sendChar(1, 9'h012, 0, 0, 0);
		step(3);
		rc(8'h14, 32'h21, 32'h21);
		rc(8'h18, '1, 32'h012);
		far_u.sendChar(1, 9'h033, 1, 0, 0);
		far_u.sendChar(1, 9'h044, 0, 1, 0);
		far_u.sendChar(0, 9'h000, 0, 0, 1);
		step(3);
		rc(8'h14, 32'he4, 32'he4);
		wr(8'h00, 32'h100);
		step(2);
		rc(8'h14, 32'he5, 32'h1);
		wr(8'h00, 32'h20);
		step(2);
		rc(8'h14, 32'h1, 32'h0);
		wr(8'h00, 32'h800);
		step(60);
		rc(8'h14, 32'h100, 32'h0);
		wr(8'h20, 32'hffff1234);
		rc(8'h20, '1, 32'h1234);
		// Sync divisors kept even, bypass never used with the undivided clock
		for (i = 0; i < 6; i++) begin
			wr(8'h04, modes[i]);
			wr(8'h20, divs[i]);
			tickGap(g);
			tickGap(g);
			chk(g, gaps[i]);
		end
		// Timeout of two units of four bit ticks, one tick per four cycles
		wr(8'h04, 32'h100);
		wr(8'h20, 32'h4);
		wr(8'h00, 32'h10);
		wr(8'h24, 32'h2);
		step(60);
		rc(8'h14, 32'h100, 32'h0);
		far_u.sendChar(1, 9'h055, 0, 0, 0);
		step(10);
		rc(8'h14, 32'h100, 32'h0);
		step(40);
		rc(8'h14, 32'h100, 32'h100);
		wr(8'h24, 32'h0);
		step(2);
		rc(8'h14, 32'h100, 32'h0);
		wr(8'h04, 32'h0);
		wr(8'h20, 32'h0);
		step(2);
		n = 0;
		repeat (600) begin
			step(1);
			n += int'(bitTickOut === 1'b1);
		end
		chk(n, 0);
		conclude();
	end
endmodule : testbench
`default_nettype wire
